// ### hw/rtc_serial_pkg.sv
// Purpose: Shared constants and types of the serial calendar clock port.
// Assumes: A 20 MHz reference clock feeds the whole design.
// Notes: Every field position, reset value, limit and timing count lives here.
package rtc_serial_pkg;
   // Reference clock and time base.
   localparam int REF_CLK_HZ = 20_000_000;
   localparam int TICK_RATE_HZ = 128;
   localparam int PRESCALE_CYCLES = REF_CLK_HZ / TICK_RATE_HZ;
   localparam int PRE_W = 18;
   localparam int DIV_W = 7;
   localparam logic [DIV_W-1:0] DIV_MAX = 7'h7F;
   // Serial frame layout, least significant bit sent first.
   localparam int FRAME_BITS = 52;
   localparam int FLAG_CLEAR_BITS = 48;
   localparam int CNT_W = 6;
   localparam int SEC_LSB = 0;
   localparam int FLAG_POS = 7;
   localparam int MIN_LSB = 8;
   localparam int HOUR_LSB = 16;
   localparam int WEEK_LSB = 24;
   localparam int DAY_LSB = 28;
   localparam int MONTH_LSB = 36;
   localparam int YEAR_LSB = 44;
   localparam int SEC_W = 7;
   localparam int BYTE_W = 8;
   localparam int WEEK_W = 4;
   // Reset values of the counters and the supply-low flag.
   localparam logic [SEC_W-1:0] SEC_RST = 7'h00;
   localparam logic [BYTE_W-1:0] MIN_RST = 8'h00;
   localparam logic [BYTE_W-1:0] HOUR_RST = 8'h00;
   localparam logic [WEEK_W-1:0] WEEK_RST = 4'h1;
   localparam logic [BYTE_W-1:0] DAY_RST = 8'h01;
   localparam logic [BYTE_W-1:0] MONTH_RST = 8'h01;
   localparam logic [BYTE_W-1:0] YEAR_RST = 8'h00;
   localparam logic FLAG_RST = 1'b1;
   // BCD limits of each counter.
   localparam logic [SEC_W-1:0] SEC_MAX = 7'h59;
   localparam logic [BYTE_W-1:0] MIN_MAX = 8'h59;
   localparam logic [BYTE_W-1:0] HOUR_MAX = 8'h23;
   localparam logic [WEEK_W-1:0] WEEK_MIN = 4'h1;
   localparam logic [WEEK_W-1:0] WEEK_MAX = 4'h7;
   localparam logic [BYTE_W-1:0] DAY_MIN = 8'h01;
   localparam logic [BYTE_W-1:0] MONTH_MIN = 8'h01;
   localparam logic [BYTE_W-1:0] MONTH_MAX = 8'h12;
   localparam logic [BYTE_W-1:0] YEAR_MAX = 8'h99;
   localparam logic [3:0] BCD_NINE = 4'h9;
   // Month codes and month lengths in BCD.
   localparam logic [BYTE_W-1:0] MON_FEB = 8'h02;
   localparam logic [BYTE_W-1:0] MON_APR = 8'h04;
   localparam logic [BYTE_W-1:0] MON_JUN = 8'h06;
   localparam logic [BYTE_W-1:0] MON_SEP = 8'h09;
   localparam logic [BYTE_W-1:0] MON_NOV = 8'h11;
   localparam logic [BYTE_W-1:0] DAYS_28 = 8'h28;
   localparam logic [BYTE_W-1:0] DAYS_29 = 8'h29;
   localparam logic [BYTE_W-1:0] DAYS_30 = 8'h30;
   localparam logic [BYTE_W-1:0] DAYS_31 = 8'h31;
   // Year unit digits that make a leap year for even and odd tens.
   localparam logic [3:0] LEAP_E0 = 4'h0;
   localparam logic [3:0] LEAP_E4 = 4'h4;
   localparam logic [3:0] LEAP_E8 = 4'h8;
   localparam logic [3:0] LEAP_O2 = 4'h2;
   localparam logic [3:0] LEAP_O6 = 4'h6;
   // Transfer mode decoded from chip enable and direction.
   typedef enum logic [1:0] {XFER_IDLE, XFER_READ, XFER_WRITE} xfer_t;
endpackage : rtc_serial_pkg

// ### hw/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Reset has already been synchronised to the clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   // Raw pins and their synchronised copy.
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] pins_s
);
   logic [WIDTH-1:0] meta_r; // First stage, read only by the second.

   // Both stages shift together while the enable is high.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         pins_s <= '0;
      end else if (en) begin
         meta_r <= pins;
         pins_s <= meta_r;
      end
   end
endmodule : pin_sync
`default_nettype wire

// ### hw/serial_calendar_clock_port.sv
// Purpose: BCD calendar clock with a three-wire serial frame port.
// Assumes: ref_clk runs at 20 MHz; serial pins are asynchronous to it.
// Notes: The serial clock is sampled, so it must stay well below ref_clk.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Counters are BCD, hours in 24-hour form.
// - Day wraps by month length, leap February.
// - Seconds low seven bits, flag on top.
// - Detector sets the supply-low flag.
// - Reads beyond 48 bits clear the flag.
// - Read when enabled and direction low.
// - First read edge snapshots, outputs seconds LSB.
// - Later edges shift next bits out in order.
// - Edges beyond 52 never alter the frame.
// - Early chip-enable drop ends read cleanly.
// - Carry during a read is not corrected.
// - Write when enabled and direction high.
// - Seconds halt from first falling edge.
// - Divider reset between first two rising edges.
// - Write samples data on rising edges, LSB first.
// - Load counters after 52 written bits.
// - Short writes discarded, extra bits ignored.
module serial_calendar_clock_port
   import rtc_serial_pkg::*;
#(
   parameter int PRESCALE = PRESCALE_CYCLES
) (
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Serial port pins.
   input wire logic chip_enable,
   input wire logic write_dir,
   input wire logic shift_clk,
   input wire logic data_in,
   output logic data_out,
   output logic data_oe,
   // Supply detector level.
   input wire logic supply_low_det
);
   // Refuse a prescaler the counter cannot hold.
   if (PRESCALE < 1 || PRESCALE > (1 << PRE_W)) begin : bad_prescale
      $error("PRESCALE out of range for the prescaler counter");
   end

   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1); // Last prescaler count.
   localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_BITS); // Frame length.
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1); // Index of last bit.
   localparam logic [CNT_W-1:0] CNT_FLAG = CNT_W'(FLAG_CLEAR_BITS); // Count before clear.
   localparam logic [CNT_W-1:0] CNT_FIRST = CNT_W'(1); // Count after first edge.

   logic [1:0] rst_sync_r; // Reset release synchroniser.
   logic rst_n_s; // Synchronised reset.
   logic ce_s; // Synchronised chip enable.
   logic wr_s; // Synchronised direction.
   logic sclk_s; // Synchronised shift clock.
   logic din_s; // Synchronised data input.
   logic det_s; // Synchronised supply detector.
   logic sclk_q; // Delayed shift clock for edge detection.
   logic ce_q; // Delayed chip enable for edge detection.
   logic sclk_rise; // Rising shift-clock edge seen.
   logic sclk_fall; // Falling shift-clock edge seen.
   logic ce_rise; // Rising chip-enable edge seen.
   xfer_t mode; // Current transfer mode.
   logic [CNT_W-1:0] bit_cnt_r; // Edges counted in this transfer.
   logic [FRAME_BITS-1:0] shift_r; // Frame shift register.
   logic [FRAME_BITS-1:0] frame_now; // Live counters packed as a frame.
   logic [FRAME_BITS-1:0] wframe; // Frame after the current write sample.
   logic write_load; // Last write bit arrives this cycle.
   logic write_halt_r; // Seconds held during a write.
   logic div_clear; // Divider held in reset.
   logic [PRE_W-1:0] pre_r; // Prescaler down to 128 Hz.
   logic [DIV_W-1:0] div_r; // Divider stages 128 Hz to 1 Hz.
   logic sec_tick; // One-second carry into the counters.
   logic flag_r; // Supply-low flag.
   logic [SEC_W-1:0] sec_r; // Seconds in BCD.
   logic [BYTE_W-1:0] min_r; // Minutes in BCD.
   logic [BYTE_W-1:0] hour_r; // Hours in BCD, 24-hour.
   logic [WEEK_W-1:0] week_r; // Day of week, 1 to 7.
   logic [BYTE_W-1:0] day_r; // Day of month in BCD.
   logic [BYTE_W-1:0] month_r; // Month in BCD with test bit on top.
   logic [BYTE_W-1:0] year_r; // Year in BCD.
   logic [BYTE_W-1:0] month_val; // Month without the test bit.
   logic [BYTE_W-1:0] days_in_month; // Last day of the current month.
   logic [BYTE_W-1:0] month_inc; // Month plus one in BCD, test bit restored later.

   // Adds one to a two-digit BCD value; the caller handles the wrap.
   function automatic logic [BYTE_W-1:0] bcd_inc(input logic [BYTE_W-1:0] v);
      logic [3:0] hi;
      logic [3:0] lo;
      hi = v[7:4];
      lo = v[3:0];
      if (lo == BCD_NINE) begin
         hi = hi + 4'h1;
         lo = 4'h0;
      end else begin
         lo = lo + 4'h1;
      end
      return {hi, lo};
   endfunction : bcd_inc

   // Tells whether a BCD year from 00 to 99 is a leap year.
   function automatic logic is_leap(input logic [BYTE_W-1:0] y);
      logic odd_tens;
      logic [3:0] units;
      odd_tens = y[4];
      units = y[3:0];
      if (odd_tens) begin
         return (units == LEAP_O2) || (units == LEAP_O6);
      end
      return (units == LEAP_E0) || (units == LEAP_E4) || (units == LEAP_E8);
   endfunction : is_leap

   // Reset asserts at once and releases after two clock edges.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n_s = rst_sync_r[1];

   // Every serial pin and the detector pass two flip-flops before any logic reads them; clk_en is used directly.
   pin_sync #(
      .WIDTH(5)
   ) u_pin_sync (
      .clk(ref_clk),
      .rst_n(rst_n_s),
      .en(clk_en),
      .pins({chip_enable, write_dir, shift_clk, data_in, supply_low_det}),
      .pins_s({ce_s, wr_s, sclk_s, din_s, det_s})
   );

   // Delayed copies of the synchronised pins give the edges.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         sclk_q <= 1'b0;
         ce_q <= 1'b0;
      end else if (clk_en) begin
         sclk_q <= sclk_s;
         ce_q <= ce_s;
      end
   end
   assign sclk_rise = clk_en && sclk_s && !sclk_q;
   assign sclk_fall = clk_en && !sclk_s && sclk_q;
   assign ce_rise = clk_en && ce_s && !ce_q;

   // Direction and chip enable pick the transfer mode.
   always_comb begin
      if (!ce_s) begin
         mode = XFER_IDLE;
      end else if (wr_s) begin
         mode = XFER_WRITE;
      end else begin
         mode = XFER_READ;
      end
   end

   // Live counters packed in frame order, year last.
   assign frame_now = {year_r, month_r, day_r, week_r, hour_r, min_r, flag_r, sec_r};
   // Incoming bit enters at the top so the first bit ends at the bottom.
   assign wframe = {din_s, shift_r[FRAME_BITS-1:1]};
   assign write_load = sclk_rise && (mode == XFER_WRITE) && (bit_cnt_r == CNT_LAST);

   // Counts shift-clock edges and saturates one past the frame.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         bit_cnt_r <= '0;
      end else if (clk_en) begin
         if (mode == XFER_IDLE) begin
            bit_cnt_r <= '0;
         end else if (sclk_rise && bit_cnt_r <= CNT_FRAME) begin
            bit_cnt_r <= bit_cnt_r + CNT_FIRST;
         end
      end
   end

   // Shift register: snapshot and shift on reads, sample on writes.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         shift_r <= '0;
      end else if (clk_en && sclk_rise) begin
         case (mode)
            XFER_READ: begin
               if (bit_cnt_r == '0) begin
                  // The snapshot is taken once; a later carry is not merged.
                  shift_r <= frame_now;
               end else if (bit_cnt_r < CNT_FRAME) begin
                  shift_r <= shift_r >> 1;
               end
            end
            XFER_WRITE: begin
               if (bit_cnt_r < CNT_FRAME) begin
                  shift_r <= wframe;
               end
            end
            default: begin
               shift_r <= shift_r; // Idle keeps the last frame.
            end
         endcase
      end
   end

   // Data line driver: bit presented on each read edge, released when idle.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         data_out <= 1'b0;
         data_oe <= 1'b0;
      end else if (clk_en) begin
         data_oe <= (mode == XFER_READ);
         if (mode != XFER_READ) begin
            data_out <= 1'b0;
         end else if (sclk_rise) begin
            if (bit_cnt_r == '0) begin
               data_out <= frame_now[SEC_LSB];
            end else if (bit_cnt_r < CNT_FRAME) begin
               data_out <= shift_r[1];
            end else begin
               // Past the frame the line is held low; captured bits stay intact.
               data_out <= 1'b0;
            end
         end
      end
   end

   // Seconds hold from the first falling edge of a write to the next enable.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         write_halt_r <= 1'b0;
      end else if (clk_en) begin
         if (ce_rise) begin
            write_halt_r <= 1'b0;
         end else if (sclk_fall && mode == XFER_WRITE) begin
            write_halt_r <= 1'b1;
         end
      end
   end

   // Divider held clear between the first and second rising edges of a write.
   assign div_clear = (mode == XFER_WRITE) && (bit_cnt_r == CNT_FIRST);

   // Time base: prescaler to 128 Hz, then seven stages down to 1 Hz.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         pre_r <= '0;
         div_r <= '0;
      end else if (clk_en) begin
         if (pre_r == PRE_LAST) begin
            pre_r <= '0;
         end else begin
            pre_r <= pre_r + PRE_W'(1);
         end
         if (div_clear) begin
            div_r <= '0;
         end else if (pre_r == PRE_LAST) begin
            div_r <= div_r + DIV_W'(1);
         end
      end
   end
   assign sec_tick = clk_en && (pre_r == PRE_LAST) && (div_r == DIV_MAX) && !write_halt_r && !div_clear;

   // Month length, with February growing in leap years.
   assign month_val = {1'b0, month_r[BYTE_W-2:0]};
   assign month_inc = bcd_inc(month_val);
   always_comb begin
      if (month_val == MON_FEB) begin
         days_in_month = is_leap(year_r) ? DAYS_29 : DAYS_28;
      end else if (month_val == MON_APR || month_val == MON_JUN || month_val == MON_SEP ||
                   month_val == MON_NOV) begin
         days_in_month = DAYS_30;
      end else begin
         days_in_month = DAYS_31;
      end
   end

   // Calendar counters: loaded by a complete write, else carried each second.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         sec_r <= SEC_RST;
         min_r <= MIN_RST;
         hour_r <= HOUR_RST;
         week_r <= WEEK_RST;
         day_r <= DAY_RST;
         month_r <= MONTH_RST;
         year_r <= YEAR_RST;
      end else if (write_load) begin
         // The host is trusted to send legal values in every field.
         sec_r <= wframe[SEC_LSB +: SEC_W];
         min_r <= wframe[MIN_LSB +: BYTE_W];
         hour_r <= wframe[HOUR_LSB +: BYTE_W];
         week_r <= wframe[WEEK_LSB +: WEEK_W];
         day_r <= wframe[DAY_LSB +: BYTE_W];
         month_r <= wframe[MONTH_LSB +: BYTE_W];
         year_r <= wframe[YEAR_LSB +: BYTE_W];
      end else if (sec_tick) begin
         if (sec_r != SEC_MAX) begin
            sec_r <= SEC_W'(bcd_inc({1'b0, sec_r}));
         end else begin
            sec_r <= SEC_RST;
            if (min_r != MIN_MAX) begin
               min_r <= bcd_inc(min_r);
            end else begin
               min_r <= MIN_RST;
               if (hour_r != HOUR_MAX) begin
                  hour_r <= bcd_inc(hour_r);
               end else begin
                  // Midnight advances day of week and day of month.
                  hour_r <= HOUR_RST;
                  week_r <= (week_r == WEEK_MAX) ? WEEK_MIN : week_r + 4'h1;
                  if (day_r != days_in_month) begin
                     day_r <= bcd_inc(day_r);
                  end else begin
                     day_r <= DAY_MIN;
                     if (month_val != MONTH_MAX) begin
                        month_r <= {month_r[BYTE_W-1], month_inc[BYTE_W-2:0]};
                     end else begin
                        // The test bit is kept across the year carry.
                        month_r <= {month_r[BYTE_W-1], MONTH_MIN[BYTE_W-2:0]};
                        year_r <= (year_r == YEAR_MAX) ? YEAR_RST : bcd_inc(year_r);
                     end
                  end
               end
            end
         end
      end
   end

   // Supply-low flag: detector set wins over a written value or a long read.
   always_ff @(posedge ref_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         flag_r <= FLAG_RST;
      end else if (clk_en) begin
         if (det_s) begin
            flag_r <= 1'b1;
         end else if (write_load) begin
            flag_r <= wframe[FLAG_POS];
         end else if (sclk_rise && mode == XFER_READ && bit_cnt_r == CNT_FLAG) begin
            flag_r <= 1'b0;
         end
      end
   end
endmodule : serial_calendar_clock_port
`default_nettype wire

// ### tb/port_monitor.sv
// Purpose: Checks the serial port pins of the calendar clock against its read and release timing.
// Assumes: Pins are driven a little after ref_clk edges and clk_en stays high.
// Notes: Latencies follow the two-flop pin synchronisers of the port.
`timescale 1ns/1ps
`default_nettype none
module port_monitor (
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Serial port pins.
   input wire logic chip_enable,
   input wire logic write_dir,
   input wire logic shift_clk,
   input wire logic data_in,
   input wire logic data_out,
   input wire logic data_oe,
   // Supply detector level.
   input wire logic supply_low_det
);
   logic [6:0] edge_cnt_r; // Read shift-clock rises seen in the current frame.
   logic [6:0] edge_cnt_nxt; // Next value of the rise count.
   logic shift_q_r; // Shift clock as sampled one cycle earlier.

   // The count restarts whenever chip enable is low and saturates so it never wraps.
   always_comb begin
      edge_cnt_nxt = edge_cnt_r;
      if (!chip_enable) begin
         edge_cnt_nxt = 7'h00;
      end else if (shift_clk && !shift_q_r && !write_dir && edge_cnt_r != 7'h7F) begin
         edge_cnt_nxt = edge_cnt_r + 7'h01;
      end
   end

   // Rise count and shift clock history.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_cnt_r <= 7'h00;
         shift_q_r <= 1'b0;
      end else begin
         edge_cnt_r <= edge_cnt_nxt;
         shift_q_r <= shift_clk;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_oe_prompt;
      $rose(chip_enable) && !write_dir |-> ##[1:6] data_oe;
   endproperty
   property p_oe_cause;
      $rose(data_oe) |-> chip_enable && !write_dir;
   endproperty
   property p_oe_steady;
      data_oe && chip_enable && !write_dir |=> data_oe;
   endproperty
   property p_oe_write_off;
      (chip_enable && write_dir) [*5] |-> !data_oe;
   endproperty
   property p_oe_idle_off;
      !chip_enable [*5] |-> !data_oe;
   endproperty
   property p_oe_release;
      $fell(chip_enable) |-> ##[1:5] !data_oe;
   endproperty
   property p_out_idle_zero;
      !chip_enable [*6] |-> !data_out;
   endproperty
   property p_out_hold;
      (data_oe && chip_enable && !write_dir && !shift_clk) [*4] |-> $stable(data_out);
   endproperty
   property p_past_frame;
      $rose(shift_clk) && chip_enable && !write_dir && edge_cnt_r >= 7'h34 |-> ##5 !data_out;
   endproperty

   a_oe_prompt: assert property (p_oe_prompt) else $error("Output enable late after read start.");
   a_oe_cause: assert property (p_oe_cause) else $error("Output enable rose outside a read.");
   a_oe_steady: assert property (p_oe_steady) else $error("Output enable dropped during a read.");
   a_oe_write_off: assert property (p_oe_write_off) else $error("Data line driven during a write.");
   a_oe_idle_off: assert property (p_oe_idle_off) else $error("Data line driven while disabled.");
   a_oe_release: assert property (p_oe_release) else $error("Data line not released in time.");
   a_out_idle_zero: assert property (p_out_idle_zero) else $error("Data output not cleared when idle.");
   a_out_hold: assert property (p_out_hold) else $error("Data output moved without a clock rise.");
   a_past_frame: assert property (p_past_frame) else $error("Bit past the frame end not zero.");

   c_full_read: cover property ($rose(shift_clk) && chip_enable && !write_dir && edge_cnt_r == 7'h33);
   c_long_read: cover property (edge_cnt_r == 7'h36);
   c_write: cover property ($rose(chip_enable) && write_dir);
endmodule : port_monitor

bind serial_calendar_clock_port port_monitor port_monitor_inst (
   .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .chip_enable(chip_enable),
   .write_dir(write_dir), .shift_clk(shift_clk), .data_in(data_in), .data_out(data_out),
   .data_oe(data_oe), .supply_low_det(supply_low_det)
);
`default_nettype wire

// ### tb/host_model.sv
// Purpose: Host side of the three-wire port, shifting whole frames in and out.
// Assumes: Shift clock phases of five ref_clk cycles, well above the port minimum.
// Notes: An undriven data line toggles every cycle so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock.
   input wire logic ref_clk,
   // Pins toward the port.
   output logic chip_enable,
   output logic write_dir,
   output logic shift_clk,
   output logic data_in,
   // Data line as driven by the port.
   input wire logic data_out,
   input wire logic data_oe
);
   logic drive_r; // High while the host drives the data line.
   logic bit_r; // Bit the host puts on the line.
   logic float_r = 1'b0; // Changing level of a line nobody drives.

   // Pins start idle with the port deselected.
   initial begin
      chip_enable = 1'b0;
      write_dir = 1'b0;
      shift_clk = 1'b0;
      drive_r = 1'b0;
      bit_r = 1'b0;
   end

   // A floating line shows no remembered value.
   always @(posedge ref_clk) begin
      float_r <= ~float_r;
   end

   // Wire level seen by both parties.
   assign data_in = drive_r ? bit_r : (data_oe ? data_out : float_r);

   // Waits whole cycles and steps just past the edge.
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : wait_clk

   // Reads n bits, each taken just before the next rising shift clock.
   task automatic read_frame(input int n, output logic [63:0] bits);
      bits = '0;
      write_dir = 1'b0;
      wait_clk(1);
      chip_enable = 1'b1;
      wait_clk(5);
      for (int i = 0; i < n; i++) begin
         shift_clk = 1'b1;
         wait_clk(5);
         shift_clk = 1'b0;
         wait_clk(5);
         bits[i] = data_in;
      end
      chip_enable = 1'b0;
      wait_clk(6);
   endtask : read_frame

   // Writes n bits, each set up a full phase before its rising edge.
   task automatic write_frame(input logic [63:0] bits, input int n);
      logic [63:0] f;
      f = bits;
      f[7] = 1'b0;
      f[43] = 1'b0;
      write_dir = 1'b1;
      wait_clk(1);
      chip_enable = 1'b1;
      drive_r = 1'b1;
      for (int i = 0; i < n; i++) begin
         bit_r = f[i];
         wait_clk(5);
         shift_clk = 1'b1;
         wait_clk(5);
         shift_clk = 1'b0;
      end
      wait_clk(5);
      chip_enable = 1'b0;
      drive_r = 1'b0;
      wait_clk(1);
      write_dir = 1'b0;
      wait_clk(6);
   endtask : write_frame
endmodule : host_model
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the serial calendar clock port.
// Assumes: A short prescale so one second is 1024 ref_clk cycles.
// Notes: Roll-over reads are placed well between two second ticks.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rtc_serial_pkg::*;
   logic ref_clk; // 20 MHz reference clock.
   logic reset_n; // Active low reset.
   logic clk_en; // Clock enable, held high.
   logic supply_low_det; // Supply detector level.
   logic chip_enable, write_dir, shift_clk, data_in, data_out, data_oe; // Port pins.
   int err_total; // Mismatches seen.
   int comparisons; // Comparisons made.
   logic [63:0] got; // Last frame read.
   logic [63:0] rst_f; // Frame expected after reset.
   logic [63:0] wf; // Frame written.
   logic [63:0] exp_f; // Frame expected after a roll-over.
   logic [7:0] yr [2] = '{8'h04, 8'h05}; // Leap and common year.
   logic [7:0] nday [2] = '{8'h29, 8'h01}; // Day after February 28.
   logic [7:0] nmon [2] = '{8'h02, 8'h03}; // Month after February 28.

   serial_calendar_clock_port #(.PRESCALE(8)) serial_calendar_clock_port_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .chip_enable(chip_enable),
      .write_dir(write_dir), .shift_clk(shift_clk), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .supply_low_det(supply_low_det)
   );

   host_model host_model_inst (
      .ref_clk(ref_clk), .chip_enable(chip_enable), .write_dir(write_dir), .shift_clk(shift_clk),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe)
   );

   // Free-running clock.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Packs fields into frame order, seconds first.
   function automatic logic [63:0] frame(input logic [7:0] s, mi, h, input logic [3:0] w,
                                         input logic [7:0] d, mo, y, input logic flag);
      return {12'h000, y, mo, d, w, h, mi, flag, s[6:0]};
   endfunction : frame

   // Compares and counts.
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // Cuts a hang short.
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_total++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      err_total = 0;
      comparisons = 0;
      reset_n = 1'b0;
      clk_en = 1'b1;
      supply_low_det = 1'b0;
      rst_f = frame({1'b0, SEC_RST}, MIN_RST, HOUR_RST, WEEK_RST, DAY_RST, MONTH_RST, YEAR_RST, FLAG_RST);
      repeat (6) @(posedge ref_clk);
      #2 reset_n = 1'b1;
      host_model_inst.wait_clk(8);
      // A 47-bit read shows the reset state and keeps the flag.
      host_model_inst.read_frame(47, got);
      check("reset_frame", got, {17'h00000, rst_f[46:0]});
      host_model_inst.read_frame(56, got);
      check("flag_kept", 64'(got[7]), 64'h1);
      check("frame_upper", 64'(got[51:8]), 64'(rst_f[51:8]));
      check("past_frame", 64'(got[55:52]), 64'h0);
      // The long read cleared the flag; an early end still gives good fields.
      host_model_inst.read_frame(28, got);
      check("flag_cleared", 64'(got[7]), 64'h0);
      check("early_end", 64'(got[27:8]), 64'(rst_f[27:8]));
      // The detector sets the flag again.
      supply_low_det = 1'b1;
      host_model_inst.wait_clk(4);
      supply_low_det = 1'b0;
      host_model_inst.read_frame(28, got);
      check("flag_set", 64'(got[7]), 64'h1);
      // Overlong writes keep 52 bits; the next day follows month and leap year.
      for (int k = 0; k < 2; k++) begin
         wf = frame(8'h59, 8'h59, 8'h23, 4'h7, 8'h28, 8'h02, yr[k], 1'b0);
         exp_f = frame(8'h00, 8'h00, 8'h00, 4'h1, nday[k], nmon[k], yr[k], 1'b0);
         host_model_inst.write_frame(wf | 64'hFFF0_0000_0000_0000, 60);
         // Longer than one second: the halted seconds must not roll before chip enable rises.
         host_model_inst.wait_clk(1100);
         host_model_inst.read_frame(52, got);
         check("written_frame", got, wf);
         host_model_inst.wait_clk(300);
         host_model_inst.read_frame(52, got);
         check("rolled_frame", got, exp_f);
      end
      // A short write leaves the counters untouched.
      host_model_inst.write_frame(frame(8'h11, 8'h22, 8'h13, 4'h3, 8'h15, 8'h06, 8'h07, 1'b0), 30);
      host_model_inst.read_frame(52, got);
      check("short_write", 64'(got[51:8]), 64'(exp_f[51:8]));
      give_verdict();
   end
endmodule : tb
`default_nettype wire
